// file: alc_defs.svh
// Constants for the asynchronous line control block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef ALC_DEFS_SVH
`define ALC_DEFS_SVH

`define ALC_NLINES     8
`define ALC_MDM_LINES  2
`define ALC_MDM_IN_W   6
`define ALC_MDM_OUT_W  5
`define ALC_WORD_W     16

// Indirect data port offset from the base, byte address.
`define ALC_REG_OFS    4'hc
// Indices 8 to 15 select lines 0 to 7.
`define ALC_IDX_GRP    2'h1
`define ALC_IDX_HI     4
`define ALC_IDX_LO     3
`define ALC_LINE_HI    2

// Line control byte.
`define ALC_B_TXEN     0
`define ALC_B_AUTO     1
`define ALC_B_RXEN     2
`define ALC_B_BRK      3
`define ALC_B_FLUSH    4
`define ALC_B_DSCE     5
`define ALC_F_MNT_HI   7
`define ALC_F_MNT_LO   6
`define ALC_CTL_HI     7

// Modem output bits 12 to 8: request to send down to user output.
`define ALC_F_MDM_HI   12
`define ALC_F_MDM_LO   8

// A master reset keeps only the rate select bit.
`define ALC_MRST_KEEP  16'h0400
`define ALC_WORD_RST   16'h0000

`define ALC_MARK       1'b1
`define ALC_SPACE      1'b0

`endif

// file: alc_pkg.sv
// Types shared by the asynchronous line control modules.
// Assumes the constants header is available by bare name.
`include "alc_defs.svh"

package alc_pkg;

    typedef enum logic [1:0] {
        ALC_NORMAL = 2'b00,
        ALC_ECHO   = 2'b01,
        ALC_LOCAL  = 2'b10,
        ALC_REMOTE = 2'b11
    } alc_maint_e;

    typedef enum logic [0:0] {
        ALC_FL_IDLE = 1'b0,
        ALC_FL_WAIT = 1'b1
    } alc_flush_e;

    typedef struct packed {
        logic       tx_run;
        logic       xoff;
        logic       brk;
        logic       rx_en;
        logic       rx_discard;
        logic       flush_req;
        logic       dma_abort;
        logic       tx_intr;
        logic       clr_flush;
        alc_flush_e fl;
    } alc_line_s;

    typedef struct packed {
        logic [`ALC_MDM_LINES-1:0][`ALC_MDM_OUT_W-1:0] pins;
    } alc_mdm_s;

    typedef struct packed {
        logic [`ALC_NLINES-1:0][`ALC_WORD_W-1:0]      word;
        logic [`ALC_WORD_W-1:0]                       rdata;
        logic                                         ack;
        logic [`ALC_NLINES-1:0]                       rxd_s1;
        logic [`ALC_NLINES-1:0]                       rxd_s2;
        logic [`ALC_NLINES-1:0]                       txd;
        logic [`ALC_NLINES-1:0]                       rx_ser;
        logic [`ALC_NLINES-1:0]                       rx_store;
        logic [`ALC_MDM_LINES-1:0][`ALC_MDM_IN_W-1:0] m_s1;
        logic [`ALC_MDM_LINES-1:0][`ALC_MDM_IN_W-1:0] m_s2;
        logic [`ALC_MDM_LINES-1:0][`ALC_MDM_IN_W-1:0] m_prev;
        logic [`ALC_MDM_LINES-1:0]                    dsc;
        logic [`ALC_MDM_LINES-1:0]                    mload;
        logic [`ALC_NLINES-1:0]                       fl_start;
    } alc_top_s;

endpackage

// file: alc_if.sv
// Interfaces between the line control top and its line and modem modules.
// Assumes all three run on the same clock.
`timescale 1ns/1ps
`include "alc_defs.svh"

interface alc_ln_if;
    logic [`ALC_CTL_HI:0] ctl;
    logic                 flush_start;
    logic                 clr_flush;
    modport top  (output ctl, flush_start, input clr_flush);
    modport line (input ctl, flush_start, output clr_flush);
endinterface

interface alc_mdm_if;
    logic [`ALC_MDM_LINES-1:0][`ALC_MDM_OUT_W-1:0] bits;
    logic [`ALC_MDM_LINES-1:0]                     load;
    logic                                          init;
    logic [`ALC_MDM_LINES-1:0][`ALC_MDM_OUT_W-1:0] pins;
    modport top (output bits, load, init, input pins);
    modport mdm (input bits, load, init, output pins);
endinterface

// file: alc_line.sv
// Per-line transmit, receive and flush sequencing.
// Assumes busy, flow and done strobes come from logic on the same clock.
`timescale 1ns/1ps
`include "alc_defs.svh"

module alc_line
    import alc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    alc_ln_if.line    lif,
    input  wire logic tx_busy,
    input  wire logic rx_active,
    input  wire logic rx_xoff,
    input  wire logic rx_xon,
    input  wire logic flush_done,
    output logic      tx_run,
    output logic      brk,
    output logic      rx_en,
    output logic      rx_discard,
    output logic      flush_req,
    output logic      dma_abort,
    output logic      tx_intr
);

    alc_line_s s;
    alc_line_s n;

    always_comb begin
        n            = s;
        n.rx_discard = 1'b0;
        n.flush_req  = 1'b0;
        n.dma_abort  = 1'b0;
        n.tx_intr    = 1'b0;
        n.clr_flush  = 1'b0;
        // A new XOFF in the same cycle as a release keeps the line stopped.
        if (!lif.ctl[`ALC_B_AUTO] || rx_xon) begin
            n.xoff = 1'b0;
        end
        if (lif.ctl[`ALC_B_AUTO] && rx_xoff) begin
            n.xoff = 1'b1;
        end
        // A character already on the wire always runs to its end; the silo is untouched.
        n.tx_run = (lif.ctl[`ALC_B_TXEN] & ~n.xoff) | (s.tx_run & tx_busy);
        n.brk    = lif.ctl[`ALC_B_BRK] & (s.brk | ~tx_busy);
        n.rx_en      = lif.ctl[`ALC_B_RXEN];
        n.rx_discard = s.rx_en & ~lif.ctl[`ALC_B_RXEN] & rx_active;
        unique case (s.fl)
            ALC_FL_IDLE: begin
                if (lif.flush_start) begin
                    n.flush_req = 1'b1;
                    n.dma_abort = 1'b1;
                    n.fl        = ALC_FL_WAIT;
                end
            end
            ALC_FL_WAIT: begin
                if (flush_done) begin
                    n.clr_flush = 1'b1;
                    n.tx_intr   = 1'b1;
                    n.fl        = ALC_FL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tx_run        = s.tx_run;
    assign brk           = s.brk;
    assign rx_en         = s.rx_en;
    assign rx_discard    = s.rx_discard;
    assign flush_req     = s.flush_req;
    assign dma_abort     = s.dma_abort;
    assign tx_intr       = s.tx_intr;
    assign lif.clr_flush = s.clr_flush;

endmodule

// file: alc_modem.sv
// Physical modem output latches for the lines that have a modem connection.
// Assumes load pulses arrive in the same cycle as the stored word changes.
`timescale 1ns/1ps
`include "alc_defs.svh"

module alc_modem
    import alc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    alc_mdm_if.mdm    mif
);

    alc_mdm_s s;
    alc_mdm_s n;

    // Only a load or a bus initialize moves the pins; a master reset does not.
    always_comb begin
        n = s;
        for (int i = 0; i < `ALC_MDM_LINES; i++) begin
            if (mif.load[i]) begin
                n.pins[i] = mif.bits[i];
            end
        end
        if (mif.init) begin
            n.pins = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign mif.pins = s.pins;

endmodule

// file: alc_top.sv
// Line control and modem output words of an eight-line asynchronous multiplexer.
// Assumes bus strobes, initialize, master reset and datapath strobes share SYS_CLK;
// receive data and modem inputs come from pins and are synchronised here.
`timescale 1ns/1ps
`include "alc_defs.svh"

module alc_top
    import alc_pkg::*;
(
    input  wire logic                        SYS_CLK,
    input  wire logic                        RST_B,
    input  wire logic                        BUS_INIT,
    input  wire logic                        MASTER_RST,
    input  wire logic [3:0]                  REG_ADDR,
    input  wire logic [4:0]                  IND_ADDR,
    input  wire logic                        REG_RD,
    input  wire logic                        REG_WR,
    input  wire logic                        REG_WORD,
    input  wire logic [`ALC_WORD_W-1:0]      REG_WDATA,
    output logic      [`ALC_WORD_W-1:0]      REG_RDATA,
    output logic                             REG_ACK,
    input  wire logic [`ALC_NLINES-1:0]      TX_CHAR_BUSY,
    input  wire logic [`ALC_NLINES-1:0]      RX_CHAR_ACTIVE,
    input  wire logic [`ALC_NLINES-1:0]      RX_XOFF_SEEN,
    input  wire logic [`ALC_NLINES-1:0]      RX_XON_SEEN,
    input  wire logic [`ALC_NLINES-1:0]      TX_FLUSH_DONE,
    input  wire logic [`ALC_NLINES-1:0]      TXD_SER,
    input  wire logic [`ALC_NLINES-1:0]      RXD_PIN,
    input  wire logic [`ALC_MDM_IN_W-1:0]    MDM_IN_L0,
    input  wire logic [`ALC_MDM_IN_W-1:0]    MDM_IN_L1,
    output logic      [`ALC_NLINES-1:0]      TX_RUN,
    output logic      [`ALC_NLINES-1:0]      RX_ENABLE,
    output logic      [`ALC_NLINES-1:0]      RX_DISCARD,
    output logic      [`ALC_NLINES-1:0]      RX_STORE_EN,
    output logic      [`ALC_NLINES-1:0]      RX_SER,
    output logic      [`ALC_NLINES-1:0]      TXD_PIN,
    output logic      [`ALC_NLINES-1:0]      TX_SILO_FLUSH,
    output logic      [`ALC_NLINES-1:0]      TX_DMA_ABORT,
    output logic      [`ALC_NLINES-1:0]      TX_INTR,
    output logic      [`ALC_MDM_LINES-1:0]   DSC_ENTRY,
    output logic      [`ALC_MDM_LINES-1:0]   USER_TX,
    output logic      [`ALC_MDM_LINES-1:0]   DTR,
    output logic      [`ALC_MDM_LINES-1:0]   DSRS,
    output logic      [`ALC_MDM_LINES-1:0]   SRTS,
    output logic      [`ALC_MDM_LINES-1:0]   RTS
);

    ////////////////////////////////////////////////////////////////////////////
    // State and wiring.

    alc_top_s                s;
    alc_top_s                n;
    logic [`ALC_NLINES-1:0]  clr_w;
    logic [`ALC_NLINES-1:0]  brk_w;
    logic                    hit;
    logic [2:0]              sel;
    alc_maint_e              mode;

    alc_mdm_if mif ();

    ////////////////////////////////////////////////////////////////////////////
    // Register access, resets, synchronisers and line data steering.

    always_comb begin
        n          = s;
        n.ack      = 1'b0;
        n.mload    = '0;
        n.fl_start = '0;
        mode       = ALC_NORMAL;
        sel        = IND_ADDR[`ALC_LINE_HI:0];
        hit        = (REG_ADDR == `ALC_REG_OFS) && REG_WORD
                     && (IND_ADDR[`ALC_IDX_HI:`ALC_IDX_LO] == `ALC_IDX_GRP);

        // Pin inputs pass two flip-flops before anything reads them.
        n.rxd_s1  = RXD_PIN;
        n.rxd_s2  = s.rxd_s1;
        n.m_s1[0] = MDM_IN_L0;
        n.m_s1[1] = MDM_IN_L1;
        n.m_s2    = s.m_s1;
        n.m_prev  = s.m_s2;

        // The hardware clear of the flush bit yields to a host write in the same cycle.
        for (int i = 0; i < `ALC_NLINES; i++) begin
            if (clr_w[i]) begin
                n.word[i][`ALC_B_FLUSH] = 1'b0;
            end
        end

        // A read followed by a write of the same word forms a read-modify-write.
        if (hit && REG_RD) begin
            n.rdata = s.word[sel];
            n.ack   = 1'b1;
        end
        if (hit && REG_WR) begin
            n.word[sel] = REG_WDATA;
            n.ack       = 1'b1;
            n.fl_start[sel] = REG_WDATA[`ALC_B_FLUSH];
            if (sel < 3'(`ALC_MDM_LINES)) begin
                n.mload[sel[0]] = 1'b1;
            end
        end

        if (MASTER_RST) begin
            for (int i = 0; i < `ALC_NLINES; i++) begin
                n.word[i] = s.word[i] & `ALC_MRST_KEEP;
            end
            n.fl_start = '0;
            n.mload    = '0;
        end
        if (BUS_INIT) begin
            for (int i = 0; i < `ALC_NLINES; i++) begin
                n.word[i] = `ALC_WORD_RST;
            end
            n.fl_start = '0;
            n.mload    = '0;
        end

        for (int i = 0; i < `ALC_MDM_LINES; i++) begin
            n.dsc[i] = s.word[i][`ALC_B_DSCE] & (s.m_s2[i] != s.m_prev[i]);
        end

        for (int i = 0; i < `ALC_NLINES; i++) begin
            mode = alc_maint_e'(s.word[i][`ALC_F_MNT_HI:`ALC_F_MNT_LO]);
            unique case (mode)
                ALC_NORMAL: begin
                    n.txd[i]      = brk_w[i] ? `ALC_SPACE : TXD_SER[i];
                    n.rx_ser[i]   = s.rxd_s2[i];
                    n.rx_store[i] = 1'b1;
                end
                ALC_ECHO: begin
                    n.txd[i]      = s.rxd_s2[i];
                    n.rx_ser[i]   = s.rxd_s2[i];
                    n.rx_store[i] = 1'b1;
                end
                ALC_LOCAL: begin
                    n.txd[i]      = `ALC_MARK;
                    n.rx_ser[i]   = TXD_SER[i];
                    n.rx_store[i] = 1'b1;
                end
                ALC_REMOTE: begin
                    n.txd[i]      = s.rxd_s2[i];
                    n.rx_ser[i]   = s.rxd_s2[i];
                    n.rx_store[i] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            s        <= '0;
            s.rxd_s1 <= '1;
            s.rxd_s2 <= '1;
            s.txd    <= '1;
            s.rx_ser <= '1;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-line sequencing.

    for (genvar g = 0; g < `ALC_NLINES; g++) begin : g_ln
        alc_ln_if lif ();

        assign lif.ctl         = s.word[g][`ALC_CTL_HI:0];
        assign lif.flush_start = s.fl_start[g];
        assign clr_w[g]        = lif.clr_flush;

        alc_line u_line (
            .clk        (SYS_CLK),
            .rst_b      (RST_B),
            .lif        (lif),
            .tx_busy    (TX_CHAR_BUSY[g]),
            .rx_active  (RX_CHAR_ACTIVE[g]),
            .rx_xoff    (RX_XOFF_SEEN[g]),
            .rx_xon     (RX_XON_SEEN[g]),
            .flush_done (TX_FLUSH_DONE[g]),
            .tx_run     (TX_RUN[g]),
            .brk        (brk_w[g]),
            .rx_en      (RX_ENABLE[g]),
            .rx_discard (RX_DISCARD[g]),
            .flush_req  (TX_SILO_FLUSH[g]),
            .dma_abort  (TX_DMA_ABORT[g]),
            .tx_intr    (TX_INTR[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Modem outputs for the connected lines.

    for (genvar g = 0; g < `ALC_MDM_LINES; g++) begin : g_mb
        assign mif.bits[g] = s.word[g][`ALC_F_MDM_HI:`ALC_F_MDM_LO];
        assign USER_TX[g]  = mif.pins[g][0];
        assign DTR[g]      = mif.pins[g][1];
        assign DSRS[g]     = mif.pins[g][2];
        assign SRTS[g]     = mif.pins[g][3];
        assign RTS[g]      = mif.pins[g][4];
    end
    assign mif.load = s.mload;
    assign mif.init = BUS_INIT;

    alc_modem u_modem (
        .clk   (SYS_CLK),
        .rst_b (RST_B),
        .mif   (mif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign REG_RDATA   = s.rdata;
    assign REG_ACK     = s.ack;
    assign RX_STORE_EN = s.rx_store;
    assign RX_SER      = s.rx_ser;
    assign TXD_PIN     = s.txd;
    assign DSC_ENTRY   = s.dsc;

endmodule

// file: alc_dce_model.sv
// Behavioural modem on lines 0 and 1 plus slow serial senders on all lines.
// Assumes modem outputs are active high and sampled on the device clock.
`timescale 1ns/1ps

module alc_dce_model #(
    parameter int DLY = 4
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [1:0] dtr,
    input  wire logic [1:0] rts,
    output logic      [5:0] mdm0,
    output logic      [5:0] mdm1,
    output logic      [7:0] rxd
);
    logic [DLY-1:0][1:0] dtr_q;
    logic [DLY-1:0][1:0] rts_q;
    logic [11:0]         cnt;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dtr_q <= '0;
            rts_q <= '0;
            cnt   <= '0;
        end else begin
            dtr_q <= {dtr_q[DLY-2:0], dtr};
            rts_q <= {rts_q[DLY-2:0], rts};
            cnt   <= cnt + 12'h1;
        end
    end

    // Set ready answers terminal ready and clear to send answers request to send, late.
    assign mdm0 = {dtr_q[DLY-1][0], rts_q[DLY-1][0], 4'h0};
    assign mdm1 = {dtr_q[DLY-1][1], rts_q[DLY-1][1], 4'h0};
    // Each line sends its own slow square wave so that echoed data can be traced.
    assign rxd  = ~cnt[11:4];
endmodule

// file: alc_top_chk.sv
// Concurrent checks on the ports of the line control top.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
`include "alc_defs.svh"

module alc_top_chk (
    input wire logic        SYS_CLK,
    input wire logic        RST_B,
    input wire logic        BUS_INIT,
    input wire logic        MASTER_RST,
    input wire logic [3:0]  REG_ADDR,
    input wire logic [4:0]  IND_ADDR,
    input wire logic        REG_RD,
    input wire logic        REG_WR,
    input wire logic        REG_WORD,
    input wire logic [15:0] REG_WDATA,
    input wire logic        REG_ACK,
    input wire logic [7:0]  TX_CHAR_BUSY,
    input wire logic [7:0]  TX_FLUSH_DONE,
    input wire logic [7:0]  TX_RUN,
    input wire logic [7:0]  TX_SILO_FLUSH,
    input wire logic [7:0]  TX_DMA_ABORT,
    input wire logic [7:0]  TX_INTR,
    input wire logic [1:0]  USER_TX,
    input wire logic [1:0]  DTR,
    input wire logic [1:0]  RTS
);
    logic acc;
    logic wr0;
    logic wr1;

    assign acc = (REG_RD | REG_WR) & REG_WORD & (REG_ADDR == 4'hc) & (IND_ADDR[4:3] == 2'h1);
    assign wr0 = acc & REG_WR & (IND_ADDR == 5'h08) & !BUS_INIT & !MASTER_RST;
    assign wr1 = acc & REG_WR & (IND_ADDR == 5'h09) & !BUS_INIT & !MASTER_RST;

    default clocking dcb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    ////////////////////////////////////////////////////////////////////////////////
    ack_after_take_a: assert property (acc |=> REG_ACK)
        else $error("accepted access without ack");
    refused_no_ack_a: assert property (!acc |=> !REG_ACK)
        else $error("ack without accepted access");
    dtr_follows_a: assert property (wr0 |-> ##4 DTR[0] == $past(REG_WDATA[9], 4))
        else $error("terminal ready pin differs from written bit");
    rts_follows_a: assert property (wr1 |-> ##4 RTS[1] == $past(REG_WDATA[12], 4))
        else $error("request to send pin differs from written bit");
    init_clears_a: assert property (BUS_INIT |=> (DTR == 2'h0) && (RTS == 2'h0)
                                    && (USER_TX == 2'h0))
        else $error("modem pins not cleared by initialize");
    mrst_keeps_a: assert property (MASTER_RST && !BUS_INIT && !acc && !$past(acc)
                                   |=> $stable(DTR) && $stable(RTS))
        else $error("modem pins moved on master reset");
    flush_abort_a: assert property (TX_SILO_FLUSH == TX_DMA_ABORT)
        else $error("flush and dma abort differ");
    intr_cause_a: assert property (TX_INTR != 8'h0
        |-> (TX_INTR & ~($past(TX_FLUSH_DONE) | $past(TX_FLUSH_DONE, 2))) == 8'h0)
        else $error("transmit interrupt without flush completion");
    char_finish_a: assert property ((TX_RUN & TX_CHAR_BUSY) != 8'h0
        |=> (TX_RUN & $past(TX_RUN & TX_CHAR_BUSY)) == $past(TX_RUN & TX_CHAR_BUSY))
        else $error("transmitter stopped during a character");
endmodule

bind alc_top alc_top_chk chk_u (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .BUS_INIT(BUS_INIT), .MASTER_RST(MASTER_RST),
    .REG_ADDR(REG_ADDR), .IND_ADDR(IND_ADDR), .REG_RD(REG_RD), .REG_WR(REG_WR),
    .REG_WORD(REG_WORD), .REG_WDATA(REG_WDATA), .REG_ACK(REG_ACK),
    .TX_CHAR_BUSY(TX_CHAR_BUSY), .TX_FLUSH_DONE(TX_FLUSH_DONE), .TX_RUN(TX_RUN),
    .TX_SILO_FLUSH(TX_SILO_FLUSH), .TX_DMA_ABORT(TX_DMA_ABORT), .TX_INTR(TX_INTR),
    .USER_TX(USER_TX), .DTR(DTR), .RTS(RTS)
);

// file: alc_top_tb.sv
// Self-checking bench for the line control top with a modem model on lines 0 and 1.
// Assumes the design, the modem model and the checker are compiled first.
`timescale 1ns/1ps
`include "alc_defs.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    $display("ERROR %s expected %0h seen %0h", n, e, g); error_cnt++; end end

module alc_top_tb;
    logic        clk, rst_b, init, mrst, rd, wr, wd, ack, ackd;
    logic [3:0]  addr;
    logic [4:0]  idx;
    logic [15:0] wdat, rdat, got;
    logic [7:0]  busy, act, xoff, xon, done, tser, rxd, run, rxen, disc, store, rser, txd;
    logic [7:0]  flsh, abrt, intr, rxd_d1, rxd_d2, rxd_d3;
    logic [5:0]  m0, m1;
    logic [1:0]  dsc, usr, dtr, dsrs, srts, rts;
    logic [15:0] exp_w [8];
    logic [31:0] seed;
    int          error_cnt, checks_done, flush_cnt, dsc_cnt, n;

    alc_top dut_u (
        .SYS_CLK(clk), .RST_B(rst_b), .BUS_INIT(init), .MASTER_RST(mrst), .REG_ADDR(addr),
        .IND_ADDR(idx), .REG_RD(rd), .REG_WR(wr), .REG_WORD(wd), .REG_WDATA(wdat),
        .REG_RDATA(rdat), .REG_ACK(ack), .TX_CHAR_BUSY(busy), .RX_CHAR_ACTIVE(act),
        .RX_XOFF_SEEN(xoff), .RX_XON_SEEN(xon), .TX_FLUSH_DONE(done), .TXD_SER(tser),
        .RXD_PIN(rxd), .MDM_IN_L0(m0), .MDM_IN_L1(m1), .TX_RUN(run), .RX_ENABLE(rxen),
        .RX_DISCARD(disc), .RX_STORE_EN(store), .RX_SER(rser), .TXD_PIN(txd),
        .TX_SILO_FLUSH(flsh), .TX_DMA_ABORT(abrt), .TX_INTR(intr), .DSC_ENTRY(dsc),
        .USER_TX(usr), .DTR(dtr), .DSRS(dsrs), .SRTS(srts), .RTS(rts));
    alc_dce_model dce_u (.clk(clk), .rst_b(rst_b), .dtr(dtr), .rts(rts), .mdm0(m0),
        .mdm1(m1), .rxd(rxd));

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        rxd_d1 <= rxd;
        rxd_d2 <= rxd_d1;
        rxd_d3 <= rxd_d2;
        if (flsh != 8'h0) flush_cnt++;
        if (dsc[0] === 1'b1) dsc_cnt++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [9:0] pins_exp();
        for (int b = 0; b < 5; b++) pins_exp[2*b +: 2] = {exp_w[1][8+b], exp_w[0][8+b]};
    endfunction

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic bus(input logic w, input logic [4:0] i, input logic [15:0] d, input logic ww);
        cyc(1);
        wr = w;
        rd = !w;
        idx = i;
        wdat = d;
        wd = ww;
        cyc(1);
        ackd = ack;
        got = rdat;
        wr = 0;
        rd = 0;
    endtask

    task automatic wrt(input int l, input logic [15:0] d);
        bus(1'b1, 5'(8 + l), d, 1'b1);
        `CHK("write ack", 1'b1, ackd)
        exp_w[l] = d;
    endtask

    task automatic rdc(input int l);
        bus(1'b0, 5'(8 + l), 16'h0000, 1'b1);
        `CHK("read ack", 1'b1, ackd)
        `CHK("read word", exp_w[l], got)
    endtask

    task automatic end_sim();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hc7abe8d8;
        {rst_b, init, mrst, rd, wr, wd, idx, wdat} = '0;
        {busy, act, xoff, xon, done, tser} = '0;
        addr = `ALC_REG_OFS;
        for (int i = 0; i < 8; i++) exp_w[i] = 16'h0000;
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1;
        for (int i = 0; i < 8; i++) rdc(i);
        bus(1'b0, 5'h03, 16'h0000, 1'b1);
        `CHK("index refused", 1'b0, ackd)
        bus(1'b1, 5'h08, 16'hffff, 1'b0);
        `CHK("byte refused", 1'b0, ackd)
        addr = 4'h8;
        bus(1'b1, 5'h08, 16'hffff, 1'b1);
        `CHK("offset refused", 1'b0, ackd)
        addr = `ALC_REG_OFS;
        repeat (24) begin
            n = int'(rnd() % 8);
            wrt(n, 16'(rnd()) & 16'hffef);
            cyc(3);
        end
        for (int i = 0; i < 8; i++) rdc(i);
        `CHK("modem pins", pins_exp(), {rts, srts, dsrs, dtr, usr})
        wrt(0, 16'h0020);
        cyc(30);
        n = dsc_cnt;
        wrt(0, 16'h0220);
        cyc(30);
        `CHK("change seen", 1'b1, dsc_cnt > n)
        wrt(0, 16'h0000);
        cyc(30);
        n = dsc_cnt;
        wrt(0, 16'h0200);
        cyc(30);
        `CHK("change ignored", n, dsc_cnt)
        wrt(2, 16'h0010);
        for (n = 0; n < 8 && flsh[2] !== 1'b1; n++) cyc(1);
        `CHK("flush pulse", 1'b1, flsh[2])
        `CHK("dma abort", 1'b1, abrt[2])
        cyc(3);
        done[2] = 1;
        cyc(1);
        done[2] = 0;
        for (n = 0; n < 3 && intr[2] !== 1'b1; n++) cyc(1);
        `CHK("flush intr", 1'b1, intr[2])
        exp_w[2] = 16'h0000;
        rdc(2);
        wrt(3, 16'h0003);
        cyc(3);
        `CHK("tx run on", 1'b1, run[3])
        xoff[3] = 1;
        cyc(1);
        xoff[3] = 0;
        cyc(3);
        `CHK("xoff stop", 1'b0, run[3])
        xon[3] = 1;
        cyc(1);
        xon[3] = 0;
        cyc(3);
        `CHK("xon restart", 1'b1, run[3])
        busy[3] = 1;
        wrt(3, 16'h0000);
        cyc(4);
        `CHK("char finishes", 1'b1, run[3])
        busy[3] = 0;
        cyc(3);
        `CHK("tx stopped", 1'b0, run[3])
        act[5] = 1;
        wrt(5, 16'h0004);
        cyc(3);
        `CHK("rx enable", 1'b1, rxen[5])
        wrt(5, 16'h0000);
        for (n = 0; n < 4 && disc[5] !== 1'b1; n++) cyc(1);
        `CHK("rx discard", 1'b1, disc[5])
        for (int m = 0; m < 4; m++) begin
            wrt(4, {8'h00, 2'(m), 6'h04});
            cyc(6);
            `CHK("tx pin mode", (m == 0) ? 1'b0 : (m == 2) ? 1'b1 : rxd_d3[4], txd[4])
            `CHK("store mode", m != 3, store[4])
            `CHK("rx source", (m == 2) ? 1'b0 : rxd_d3[4], rser[4])
        end
        tser[4] = 1;
        busy[4] = 1;
        wrt(4, 16'h000d);
        cyc(4);
        `CHK("break waits", 1'b1, txd[4])
        busy[4] = 0;
        cyc(4);
        `CHK("break space", 1'b0, txd[4])
        wrt(4, 16'h0005);
        cyc(4);
        `CHK("break ends", 1'b1, txd[4])
        wrt(0, 16'h1f00);
        wrt(1, 16'h1f00);
        cyc(4);
        `CHK("pins loaded", 10'h3ff, {rts, srts, dsrs, dtr, usr})
        mrst = 1;
        cyc(1);
        mrst = 0;
        cyc(2);
        `CHK("pins kept", 10'h3ff, {rts, srts, dsrs, dtr, usr})
        for (int i = 0; i < 8; i++) begin
            exp_w[i] &= 16'h0400;
            rdc(i);
        end
        wrt(0, 16'h0000);
        wrt(1, 16'h0400);
        cyc(4);
        `CHK("pins reloaded", pins_exp(), {rts, srts, dsrs, dtr, usr})
        init = 1;
        cyc(1);
        init = 0;
        cyc(2);
        `CHK("pins cleared", 10'h000, {rts, srts, dsrs, dtr, usr})
        for (int i = 0; i < 8; i++) begin
            exp_w[i] = 16'h0000;
            rdc(i);
        end
        `CHK("flush count", 1, flush_cnt)
        end_sim();
    end
endmodule
